/* File: bench/rmp_host.sv */
// Host controller model that sends program messages and reads responses.
`timescale 1ns/1ps
module rmp_host (
    input  wire logic       CLK,
    input  wire logic       RX_READY,
    input  wire logic [7:0] TX_DATA,
    input  wire logic       TX_END,
    input  wire logic       TX_VALID,
    output logic      [7:0] RX_DATA,
    output logic            RX_END,
    output logic            RX_VALID,
    output logic            HOST_READ_REQ,
    output logic            TX_READY,
    output logic            DISCARD_RESP
);
    logic [9:0] got[$];
    int         seed = 32'hd24f;
    int         hangs = 0;
    initial begin
        {RX_DATA, RX_END, RX_VALID, HOST_READ_REQ, TX_READY, DISCARD_RESP} = 13'h0;
    end
    // The reader stalls about one cycle in four.
    always @(negedge CLK) TX_READY <= HOST_READ_REQ && ($random(seed) & 3) != 0;
    always @(posedge CLK) if (TX_VALID && TX_READY) got.push_back({1'b0, TX_END, TX_DATA});
    // Bytes go out back to back without waiting for any response.
    task automatic send(input string s, input logic end_last);
        int t;
        for (int i = 0; i < s.len(); i++) begin
            @(negedge CLK);
            RX_DATA = s[i];
            RX_END = end_last && i == s.len() - 1;
            RX_VALID = 1'b1;
            // Ready is judged at the falling edge, where it has settled, and the byte is taken at the next rise.
            for (t = 0; t < 300 && RX_READY !== 1'b1; t++) begin
                @(negedge CLK);
            end
            if (t == 300) hangs++;
            @(posedge CLK);
        end
        @(negedge CLK);
        {RX_VALID, RX_END} = 2'b00;
        RX_DATA = ~RX_DATA;
    endtask
    task automatic set_read(input logic on);
        @(negedge CLK);
        HOST_READ_REQ = on;
    endtask
    task automatic discard();
        @(negedge CLK);
        DISCARD_RESP = 1'b1;
        @(negedge CLK);
        DISCARD_RESP = 1'b0;
    endtask
endmodule

/* File: bench/rmp_monitor.sv */
// Checker of the parser's port timing and characters.
`timescale 1ns/1ps
module rmp_monitor
    import rmp_pkg::*;
(
    input wire logic       CLK,
    input wire logic       RST_N,
    input wire logic       RX_VALID,
    input wire logic       HOST_READ_REQ,
    input wire logic [7:0] TX_DATA,
    input wire logic       TX_END,
    input wire logic       TX_VALID,
    input wire logic       TX_READY,
    input wire logic       DISCARD_RESP,
    input wire logic [7:0] UNIT_DATA,
    input wire logic       UNIT_SEP,
    input wire logic       UNIT_END,
    input wire logic       UNIT_VALID,
    input wire logic       UNIT_READY,
    input wire rmp_unit_s  UNIT_INFO,
    input wire logic       RESP_READY,
    input wire logic       MSG_DONE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_took(logic [7:0] ch);
        UNIT_VALID && UNIT_READY && UNIT_DATA == ch;
    endsequence
    // A stalled reader keeps the byte unless a new message or a discard cancels it.
    sequence s_tx_wait;
        TX_VALID && !TX_READY && HOST_READ_REQ && !RX_VALID && !DISCARD_RESP;
    endsequence
    a_tx_final_lf: assert property (TX_VALID && TX_END |-> TX_DATA == CH_LF)
        else $error("final response byte is not a line feed");
    a_tx_holds: assert property (s_tx_wait |=> TX_VALID && $stable(TX_DATA) && $stable(TX_END))
        else $error("response byte changed before it was taken");
    a_unit_holds: assert property (UNIT_VALID && !UNIT_READY |=> UNIT_VALID && $stable(UNIT_DATA))
        else $error("unit byte changed before it was taken");
    a_comma_sep: assert property (UNIT_VALID && UNIT_SEP |-> UNIT_DATA == CH_COMMA)
        else $error("data separator flag on a non-comma byte");
    a_semi_ends: assert property (UNIT_VALID && UNIT_DATA == CH_SEMI |-> UNIT_END)
        else $error("semicolon did not end the unit");
    a_star_common: assert property (s_took(CH_STAR) |=> UNIT_INFO.common)
        else $error("asterisk did not mark a common command");
    a_query_mark: assert property (s_took(CH_QUERY) |=> UNIT_INFO.query)
        else $error("question mark did not mark a query");
    a_done_pulse: assert property (MSG_DONE |=> !MSG_DONE)
        else $error("message done held longer than one cycle");
    a_done_answer: assert property (MSG_DONE |=> ##[0:2] TX_VALID)
        else $error("no response byte after message done");
    a_readout_refuse: assert property (TX_VALID |-> !RESP_READY)
        else $error("response byte accepted during readout");
    cover property (s_took(CH_STAR));
endmodule
bind rmp_top rmp_monitor u_rmp_monitor (.CLK(CLK), .RST_N(RST_N), .RX_VALID(RX_VALID),
    .HOST_READ_REQ(HOST_READ_REQ), .TX_DATA(TX_DATA), .TX_END(TX_END), .TX_VALID(TX_VALID),
    .TX_READY(TX_READY), .DISCARD_RESP(DISCARD_RESP), .UNIT_DATA(UNIT_DATA), .UNIT_SEP(UNIT_SEP),
    .UNIT_END(UNIT_END), .UNIT_VALID(UNIT_VALID), .UNIT_READY(UNIT_READY), .UNIT_INFO(UNIT_INFO),
    .RESP_READY(RESP_READY), .MSG_DONE(MSG_DONE));

/* File: bench/rmp_top_test.sv */
// Self-checking bench for the remote message parser.
`timescale 1ns/1ps
module rmp_top_test
    import rmp_pkg::*;
;
    logic       CLK = 1'b0, RST_N = 1'b0;
    logic [7:0] RX_DATA, TX_DATA, UNIT_DATA, RESP_DATA = 8'h00;
    logic       RX_END, RX_VALID, RX_READY, HOST_READ_REQ, TX_END, TX_VALID, TX_READY, DISCARD_RESP;
    logic       UNIT_HDR, UNIT_SEP, UNIT_END, UNIT_VALID, MSG_DONE, QUERY_ERROR, STALLED, RESP_READY;
    logic       UNIT_READY = 1'b0, RESP_UNIT_END = 1'b0, RESP_VALID = 1'b0;
    rmp_unit_s  UNIT_INFO;
    logic [9:0] units[$];
    int         seed = 32'hd24f, err_total = 0, tests_run = 0, dones = 0, qerrs = 0, q0;
    string      msg, rsp;
    rmp_top u_rmp_top (.CLK(CLK), .RST_N(RST_N), .RX_DATA(RX_DATA), .RX_END(RX_END), .RX_VALID(RX_VALID),
        .RX_READY(RX_READY), .HOST_READ_REQ(HOST_READ_REQ), .TX_DATA(TX_DATA), .TX_END(TX_END),
        .TX_VALID(TX_VALID), .TX_READY(TX_READY), .DISCARD_RESP(DISCARD_RESP), .UNIT_DATA(UNIT_DATA),
        .UNIT_HDR(UNIT_HDR), .UNIT_SEP(UNIT_SEP), .UNIT_END(UNIT_END), .UNIT_VALID(UNIT_VALID),
        .UNIT_READY(UNIT_READY), .UNIT_INFO(UNIT_INFO), .RESP_DATA(RESP_DATA), .RESP_UNIT_END(RESP_UNIT_END),
        .RESP_VALID(RESP_VALID), .RESP_READY(RESP_READY), .MSG_DONE(MSG_DONE), .QUERY_ERROR(QUERY_ERROR),
        .STALLED(STALLED));
    rmp_host u_rmp_host (.CLK(CLK), .RX_READY(RX_READY), .TX_DATA(TX_DATA), .TX_END(TX_END),
        .TX_VALID(TX_VALID), .RX_DATA(RX_DATA), .RX_END(RX_END), .RX_VALID(RX_VALID),
        .HOST_READ_REQ(HOST_READ_REQ), .TX_READY(TX_READY), .DISCARD_RESP(DISCARD_RESP));
    always #2.5 CLK = ~CLK;
    always @(negedge CLK) UNIT_READY <= ($random(seed) & 3) != 0;
    always @(posedge CLK) begin
        if (UNIT_VALID && UNIT_READY) units.push_back({UNIT_END, UNIT_SEP, UNIT_DATA});
        if (MSG_DONE === 1'b1) dones++;
        if (QUERY_ERROR === 1'b1) qerrs++;
    end
    function automatic string rnd_ch(input logic [7:0] base, input int span);
        return string'(base + 8'(($random(seed) & 32'h7fff) % span));
    endfunction
    function automatic logic [9:0] exp_unit(input logic [7:0] b, input logic last);
        return {b == CH_SEMI || last, b == CH_COMMA, b};
    endfunction
    function automatic int level(input int k);
        case (k)
            0: return units.size();
            1: return dones;
            2: return u_rmp_host.got.size();
            default: return qerrs;
        endcase
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_until(input int k, input int n);
        int t;
        for (t = 0; t < 3000 && level(k) < n; t++) @(posedge CLK);
        if (t == 3000) begin
            err_total++;
            $display("BAD wait %0d expected %0d seen %0d", k, n, level(k));
            complete_run();
        end
    endtask
    task automatic check_units(input string s);
        wait_until(0, s.len());
        for (int i = 0; i < s.len(); i++) begin
            check("unit byte", units[i], exp_unit(s[i], i == s.len() - 1));
        end
        units.delete();
    endtask
    task automatic resp(input logic [7:0] b, input logic sep);
        int t;
        @(negedge CLK);
        {RESP_DATA, RESP_UNIT_END, RESP_VALID} = {b, sep, 1'b1};
        // Ready is judged where it has settled; the byte is taken at the following rising edge.
        for (t = 0; t < 300 && RESP_READY !== 1'b1; t++) begin
            @(negedge CLK);
        end
        if (t == 300) check("resp taken", 10'd0, 10'd1);
        @(posedge CLK);
        @(negedge CLK);
        {RESP_DATA, RESP_VALID} = {~b, 1'b0};
    endtask
    task automatic query(input string r, input string q);
        for (int i = 0; i < r.len(); i++) resp(r[i] == CH_SEMI ? 8'h55 : r[i], r[i] == CH_SEMI);
        u_rmp_host.send(q, 1'b0);
        check_units(q);
        wait_until(1, dones + 1);
    endtask
    initial begin
        repeat (12) @(posedge CLK);
        @(negedge CLK);
        RST_N = 1'b1;
        for (int m = 0; m < 4; m++) begin
            msg = {rnd_ch(8'h41, 26), rnd_ch(8'h30, 10), ":", rnd_ch(8'h41, 26), " ", rnd_ch(8'h30, 10), ",",
                   rnd_ch(8'h30, 10), ";", rnd_ch(8'h41, 26), " ", rnd_ch(8'h30, 10)};
            if (m == 3) msg = "*AB;*CD 7";
            if (m != 1) msg = {msg, "\n"};
            u_rmp_host.send(msg, m != 0);
            check_units(msg);
        end
        check("done count", 10'(dones), 10'd0);
        $display("test units done");
        rsp = {rnd_ch(8'h41, 26), rnd_ch(8'h30, 10), ";", rnd_ch(8'h30, 10), "\n"};
        query(rsp.substr(0, 3), "AB?;:CD?\n");
        u_rmp_host.set_read(1'b1);
        wait_until(2, rsp.len());
        for (int i = 0; i < rsp.len(); i++) begin
            check("tx byte", u_rmp_host.got[i], {1'b0, i == rsp.len() - 1, rsp[i]});
        end
        q0 = qerrs;
        wait_until(3, q0 + 1);
        u_rmp_host.set_read(1'b0);
        check("read error", 10'(qerrs > q0), 10'd1);
        check("tx count", 10'(u_rmp_host.got.size()), 10'(rsp.len()));
        $display("test response done");
        query("ABCDEF", "Q?\n");
        u_rmp_host.set_read(1'b1);
        wait_until(2, rsp.len() + 1);
        u_rmp_host.set_read(1'b0);
        q0 = qerrs;
        u_rmp_host.send("R 1\n", 1'b0);
        check_units("R 1\n");
        wait_until(3, q0 + 1);
        check("tx after abort", 10'(TX_VALID), 10'd0);
        $display("test abort done");
        query("K7", "S?\n");
        repeat (3) @(negedge CLK);
        check("tx pending", 10'(TX_VALID), 10'd1);
        u_rmp_host.discard();
        repeat (2) @(negedge CLK);
        check("tx discarded", 10'(TX_VALID), 10'd0);
        check("stall", 10'(STALLED), 10'd0);
        check("host hangs", 10'(u_rmp_host.hangs), 10'd0);
        $display("test discard done");
        complete_run();
    end
endmodule

/* File: rtl/rmp_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module rmp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input  wire logic             CLK,
    input  wire logic             RST_N,
    input  wire logic [WIDTH-1:0] IN_DATA,
    input  wire logic             IN_VALID,
    output logic                  IN_READY,
    output logic      [WIDTH-1:0] OUT_DATA,
    output logic                  OUT_VALID,
    input  wire logic             OUT_READY,
    input  wire logic             FLUSH
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    assign IN_READY  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign OUT_VALID = wr_ptr != rd_ptr;
    assign OUT_DATA  = mem[rd_ptr[AW-1:0]];
    assign push      = IN_VALID && IN_READY && !FLUSH;
    assign pop       = OUT_VALID && OUT_READY;

    always_ff @(posedge CLK) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= IN_DATA;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (FLUSH) begin
            rd_ptr <= wr_ptr;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

/* File: rtl/rmp_pkg.sv */
// Package for the remote message parser: characters, sizes, carriers and states.
package rmp_pkg;
    localparam logic [7:0] CH_LF    = 8'h0a;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_SEMI  = 8'h3b;
    localparam logic [7:0] CH_COMMA = 8'h2c;
    localparam logic [7:0] CH_COLON = 8'h3a;
    localparam logic [7:0] CH_STAR  = 8'h2a;
    localparam logic [7:0] CH_QUERY = 8'h3f;
    localparam int BUF_DEPTH  = 1024;
    localparam int BUF_AW     = 10;
    localparam int FIFO_DEPTH = 32;
    localparam int HDR_DEPTH  = 64;
    localparam int HDR_AW     = 6;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } rmp_byte_s;

    typedef struct packed {
        logic [HDR_AW-1:0] prefix_len;
        logic              common;
        logic              query;
        logic              bad;
    } rmp_unit_s;

    typedef enum logic [2:0] {
        ST_START  = 3'b000,
        ST_HEADER = 3'b001,
        ST_DATA   = 3'b010,
        ST_FLUSH  = 3'b011
    } rmp_parse_e;
endpackage

/* File: rtl/rmp_top.sv */
// Remote message parser: splits program messages into units and sequences responses.
`timescale 1ns/1ps
module rmp_top
    import rmp_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RST_N,
    // Host byte link, receive side.
    input  wire logic [7:0] RX_DATA,
    input  wire logic       RX_END,
    input  wire logic       RX_VALID,
    output logic            RX_READY,
    // Host read request and response byte stream.
    input  wire logic       HOST_READ_REQ,
    output logic [7:0]      TX_DATA,
    output logic            TX_END,
    output logic            TX_VALID,
    input  wire logic       TX_READY,
    input  wire logic       DISCARD_RESP,
    // Parsed unit toward the command executor.
    output logic [7:0]      UNIT_DATA,
    output logic            UNIT_HDR,
    output logic            UNIT_SEP,
    output logic            UNIT_END,
    output logic            UNIT_VALID,
    input  wire logic       UNIT_READY,
    output rmp_unit_s       UNIT_INFO,
    // Response units from the executor, one byte at a time.
    input  wire logic [7:0] RESP_DATA,
    input  wire logic       RESP_UNIT_END,
    input  wire logic       RESP_VALID,
    output logic            RESP_READY,
    output logic            MSG_DONE,
    output logic            QUERY_ERROR,
    output logic            STALLED
);
    rmp_byte_s         fifo_in;
    rmp_byte_s         fifo_out;
    logic              fifo_valid;
    logic              fifo_take;
    rmp_parse_e        state;
    logic [7:0]        hdr_mem [HDR_DEPTH];
    logic [HDR_AW-1:0] hdr_len;
    logic [HDR_AW-1:0] level_len;
    logic [HDR_AW-1:0] last_colon;
    logic              msg_query;
    logic              msg_open;
    logic              unit_bad;
    logic              unit_common;
    logic              unit_query;
    logic [7:0]        tx_mem [BUF_DEPTH];
    logic [BUF_AW:0]   tx_wr;
    logic [BUF_AW:0]   tx_rd;
    logic              tx_units;
    logic              resp_ready_msg;
    logic              tx_sending;
    logic [7:0]        cur;
    logic              is_lf_term;
    logic              msg_last;

    function automatic logic is_alnum(input logic [7:0] c);
        return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5a) || (c >= 8'h61 && c <= 8'h7a);
    endfunction

    assign fifo_in = '{data: RX_DATA, last: RX_END};
    rmp_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .CLK       (CLK),
        .RST_N     (RST_N),
        .IN_DATA   (fifo_in),
        .IN_VALID  (RX_VALID),
        .IN_READY  (RX_READY),
        .OUT_DATA  (fifo_out),
        .OUT_VALID (fifo_valid),
        .OUT_READY (fifo_take),
        .FLUSH     (1'b0)
    );

    assign cur = fifo_out.data;
    // A lone line feed or a line feed with END closes; END alone keeps its byte.
    assign is_lf_term = cur == CH_LF;
    assign msg_last   = is_lf_term || fifo_out.last;

    // Units go out only when the executor is ready; header bytes are echoed to it too.
    always_comb begin
        fifo_take  = 1'b0;
        UNIT_VALID = 1'b0;
        UNIT_DATA  = cur;
        UNIT_HDR   = state == ST_HEADER;
        UNIT_SEP   = 1'b0;
        UNIT_END   = 1'b0;
        if (fifo_valid) begin
            if (state == ST_FLUSH) begin
                fifo_take = 1'b1;
            end else begin
                UNIT_VALID = !(is_lf_term && state == ST_START);
                UNIT_END   = cur == CH_SEMI || msg_last;
                UNIT_SEP   = state == ST_DATA && cur == CH_COMMA;
                fifo_take  = UNIT_READY || !UNIT_VALID;
            end
        end
    end

    assign UNIT_INFO = '{prefix_len: level_len, common: unit_common, query: unit_query, bad: unit_bad};

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state       <= ST_START;
            hdr_len     <= '0;
            level_len   <= '0;
            last_colon  <= '0;
            unit_bad    <= 1'b0;
            unit_common <= 1'b0;
            unit_query  <= 1'b0;
            msg_query   <= 1'b0;
            msg_open    <= 1'b0;
        end else if (fifo_valid && fifo_take) begin
            msg_open <= !msg_last;
            case (state)
                ST_START: begin
                    unit_bad    <= 1'b0;
                    unit_query  <= 1'b0;
                    unit_common <= cur == CH_STAR;
                    if (cur == CH_COLON) begin
                        level_len <= '0;
                        hdr_len   <= '0;
                        state     <= ST_HEADER;
                    end else if (cur == CH_STAR) begin
                        hdr_len <= '0;
                        state   <= ST_HEADER;
                    end else if (is_alnum(cur)) begin
                        hdr_len <= level_len;
                        state   <= ST_HEADER;
                    end else if (!msg_last && cur != CH_SEMI && cur != CH_SPACE) begin
                        unit_bad <= 1'b1;
                        state    <= ST_FLUSH;
                    end
                end
                ST_HEADER: begin
                    if (cur == CH_COLON) begin
                        last_colon <= hdr_len;
                        hdr_len    <= hdr_len + 1'b1;
                    end else if (cur == CH_QUERY) begin
                        unit_query <= 1'b1;
                        msg_query  <= 1'b1;
                    end else if (cur == CH_SPACE) begin
                        state <= ST_DATA;
                    end else if (cur == CH_SEMI || msg_last) begin
                        state <= ST_START;
                    end else if (is_alnum(cur)) begin
                        hdr_len <= hdr_len + 1'b1;
                    end else begin
                        unit_bad <= 1'b1;
                        state    <= ST_FLUSH;
                    end
                    if ((cur == CH_SEMI || msg_last || cur == CH_SPACE) && !unit_common) begin
                        level_len <= last_colon;
                    end
                end
                ST_DATA: begin
                    if (cur == CH_SEMI || msg_last) begin
                        state <= ST_START;
                    end
                end
                default: begin
                    if (cur == CH_SEMI || msg_last) begin
                        state <= ST_START;
                    end
                end
            endcase
            if (msg_last) begin
                level_len <= '0;
                msg_query <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (fifo_valid && fifo_take && state == ST_HEADER && cur != CH_QUERY && cur != CH_SPACE) begin
            hdr_mem[hdr_len] <= cur;
        end
    end

    // Response buffer: units joined by semicolons, closed by line feed with END.
    assign RESP_READY     = (tx_wr - tx_rd) < (BUF_AW+1)'(BUF_DEPTH - 2) && !tx_sending;
    assign resp_ready_msg = fifo_valid && fifo_take && msg_last && (msg_query || unit_query);
    assign STALLED        = !RX_READY && !RESP_READY;

    always_ff @(posedge CLK) begin
        if (RESP_VALID && RESP_READY) begin
            tx_mem[tx_wr[BUF_AW-1:0]] <= RESP_UNIT_END ? CH_SEMI : RESP_DATA;
        end else if (resp_ready_msg) begin
            tx_mem[tx_wr[BUF_AW-1:0]] <= CH_LF;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_wr       <= '0;
            tx_rd       <= '0;
            tx_units    <= 1'b0;
            tx_sending  <= 1'b0;
            MSG_DONE    <= 1'b0;
            QUERY_ERROR <= 1'b0;
        end else begin
            MSG_DONE    <= resp_ready_msg;
            QUERY_ERROR <= 1'b0;
            if (DISCARD_RESP || (tx_sending && RX_VALID && TX_VALID)) begin
                tx_rd      <= tx_wr;
                tx_sending <= 1'b0;
                tx_units   <= 1'b0;
                QUERY_ERROR <= !DISCARD_RESP;
            end else begin
                if (RESP_VALID && RESP_READY) begin
                    tx_wr    <= tx_wr + 1'b1;
                    tx_units <= 1'b1;
                end else if (resp_ready_msg) begin
                    tx_wr      <= tx_wr + 1'b1;
                    tx_sending <= 1'b1;
                end
                if (HOST_READ_REQ && !tx_sending) begin
                    QUERY_ERROR <= 1'b1;
                end
                if (TX_VALID && TX_READY) begin
                    tx_rd <= tx_rd + 1'b1;
                    if (TX_END) begin
                        tx_sending <= 1'b0;
                        tx_units   <= 1'b0;
                    end
                end
            end
        end
    end

    assign TX_VALID = tx_sending && tx_rd != tx_wr && !msg_open;
    assign TX_DATA  = tx_mem[tx_rd[BUF_AW-1:0]];
    assign TX_END   = TX_VALID && (tx_rd + 1'b1) == tx_wr;
endmodule
